// *** src/pcs_consts.svh ***
// Offsets, field positions, reset values and divider counts of the clock selector
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// Register offsets
`define PCS_MODE_ADDR      8'h14
`define PCS_PERIPH_ADDR    8'h15

// Reset values
`define PCS_MODE_RESET     8'h00
`define PCS_PERIPH_RESET   8'h00

// Mode register fields
`define PCS_SEL_EXT_BIT    0
`define PCS_QUARTER_BIT    1
`define PCS_HALVE_BIT      3
`define PCS_TICK_SRC_BIT   5

// Peripheral register fields
`define PCS_DBL_RATE_BIT   0
`define PCS_CHOP_LO_BIT    2
`define PCS_CHOP_HI_BIT    3

// Nominal source rates
`define PCS_INT_OSC_HZ     1000000
`define PCS_EXT_OSC_HZ     32768

// Half periods in source rising edges
`define PCS_HALF_DIV32     10'h010
`define PCS_HALF_DIV100    10'h032
`define PCS_HALF_DIV200    10'h064
`define PCS_HALF_DIV500    10'h0fa
`define PCS_HALF_DIV1000   10'h1f4

`endif

// *** src/pcs_pkg.sv ***
// Types shared by the clock selector files
package pcs_pkg;
   typedef enum logic [1:0] {
      PCS_CHOP_LOW  = 2'b00,
      PCS_CHOP_HIGH = 2'b01,
      PCS_CHOP_D500 = 2'b10,
      PCS_CHOP_D1K  = 2'b11
   } pcs_chop_t;
   typedef logic [9:0] pcs_half_t;
endpackage

// *** src/pcs_divider.sv ***
// Restartable square-wave divider counting source rising edges
`timescale 1ns/1ps
module pcs_divider
   import pcs_pkg::*;
(
   // Clock and reset
   input  wire logic      ref_clk,
   input  wire logic      sys_rst,
   // Control
   input  wire logic      restart,
   input  wire logic      tick,
   input  wire pcs_half_t half_count,
   // Output
   output logic           div_out
);
   pcs_half_t cnt_reg;

   // Count source edges, toggle each half period
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 10'h000;
         div_out <= 1'b0;
      end else if (restart) begin
         cnt_reg <= 10'h000;
         div_out <= 1'b0;
      end else if (tick) begin
         if (cnt_reg == half_count - 10'h001) begin
            cnt_reg <= 10'h000;
            div_out <= ~div_out;
         end else begin
            cnt_reg <= cnt_reg + 10'h001;
         end
      end
   end
endmodule

// *** src/pcs_clock_selector.sv ***
// Peripheral clock selector: main, system, doubler, chopper and tick clocks
//
// Summary of operation
// - Main clock is the internal oscillator unless external is selected, then external or its half.
// - System clock is the main clock, or the main clock over four when quarter select is set.
// - With internal main, the doubler runs at main over 200, or over 100 when rate select is set.
// - With external main, the doubler runs at external over 32 whatever the rate select.
// - Chopper output is low, high, system over 500 or system over 1000 by its two-bit field.
// - Tick clock is system over 1000, or external over 32 when the tick source bit is set.
// - One tick clock output feeds both the timer and the LCD.
// - Internal source is taken as 1 MHz and external as 32768 Hz.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_clock_selector
   import pcs_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // Oscillator pins
   input  wire logic       internal_osc_clock,
   input  wire logic       external_osc_clock,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Derived clocks
   output logic            main_clock,
   output logic            system_clock,
   output logic            doubler_clock,
   output logic            chopper_ctrl,
   output logic            timer_lcd_clock
);
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction

   logic [7:0] mode_reg;
   logic [7:0] periph_reg;
   logic [7:0] mode_prev_reg;
   logic [7:0] periph_prev_reg;
   logic [2:0] int_sync_reg;
   logic [2:0] ext_sync_reg;
   logic       ext_half_reg;
   logic [1:0] quarter_reg;
   logic       main_next;
   logic       sys_next;
   logic       int_rise;
   logic       ext_rise;
   logic       main_rise;
   logic       sys_rise;
   logic       restart;
   logic       sel_ext;
   logic       halve;
   logic       quarter;
   logic       tick_src;
   logic       dbl_rate;
   pcs_chop_t  chop_sel;
   pcs_half_t  dbl_half;
   pcs_half_t  chop_half;
   pcs_half_t  tick_half;
   logic       dbl_tick;
   logic       tmr_tick;
   logic       dbl_div;
   logic       chop_div;
   logic       tmr_div;

   assign sel_ext  = mode_reg[`PCS_SEL_EXT_BIT];
   assign halve    = mode_reg[`PCS_HALVE_BIT];
   assign quarter  = mode_reg[`PCS_QUARTER_BIT];
   assign tick_src = mode_reg[`PCS_TICK_SRC_BIT];
   assign dbl_rate = periph_reg[`PCS_DBL_RATE_BIT];
   assign chop_sel = pcs_chop_t'(periph_reg[`PCS_CHOP_HI_BIT:`PCS_CHOP_LO_BIT]);

   // Register writes; unused bits kept for software readback
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg   <= `PCS_MODE_RESET;
         periph_reg <= `PCS_PERIPH_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `PCS_MODE_ADDR) begin
            mode_reg <= reg_wdata;
         end
         if (reg_addr == `PCS_PERIPH_ADDR) begin
            periph_reg <= reg_wdata;
         end
      end
   end

   // Read data one cycle after the strobe, zero when unmapped
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `PCS_MODE_ADDR:   reg_rdata <= mode_reg;
            `PCS_PERIPH_ADDR: reg_rdata <= periph_reg;
            default:          reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Any change of selection restarts all dividers
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_prev_reg   <= `PCS_MODE_RESET;
         periph_prev_reg <= `PCS_PERIPH_RESET;
      end else begin
         mode_prev_reg   <= mode_reg;
         periph_prev_reg <= periph_reg;
      end
   end
   assign restart = (mode_prev_reg != mode_reg) || (periph_prev_reg != periph_reg);

   // Oscillator pins are asynchronous; stage 0 feeds only stage 1
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_sync_reg <= 3'h0;
         ext_sync_reg <= 3'h0;
      end else begin
         int_sync_reg <= {int_sync_reg[1:0], internal_osc_clock};
         ext_sync_reg <= {ext_sync_reg[1:0], external_osc_clock};
      end
   end
   assign int_rise = rise(int_sync_reg[1], int_sync_reg[2]);
   assign ext_rise = rise(ext_sync_reg[1], ext_sync_reg[2]);

   // External halving toggle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_half_reg <= 1'b0;
      end else if (restart) begin
         ext_half_reg <= 1'b0;
      end else if (ext_rise) begin
         ext_half_reg <= ~ext_half_reg;
      end
   end

   // Main clock level
   always_comb begin
      if (!sel_ext) begin
         main_next = int_sync_reg[1];
      end else if (halve) begin
         main_next = ext_half_reg;
      end else begin
         main_next = ext_sync_reg[1];
      end
   end
   assign main_rise = rise(main_next, main_clock);

   // Quarter counter on main rising edges
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         quarter_reg <= 2'h0;
      end else if (restart) begin
         quarter_reg <= 2'h0;
      end else if (main_rise) begin
         quarter_reg <= quarter_reg + 2'h1;
      end
   end
   assign sys_next = quarter ? quarter_reg[1] : main_next;
   assign sys_rise = rise(sys_next, system_clock);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         main_clock   <= 1'b0;
         system_clock <= 1'b0;
      end else begin
         main_clock   <= main_next;
         system_clock <= sys_next;
      end
   end

   // Doubler source and ratio
   always_comb begin
      if (sel_ext) begin
         dbl_tick = ext_rise;
         dbl_half = `PCS_HALF_DIV32;
      end else begin
         dbl_tick = main_rise;
         dbl_half = dbl_rate ? `PCS_HALF_DIV100 : `PCS_HALF_DIV200;
      end
   end

   assign chop_half = (chop_sel == PCS_CHOP_D1K) ? `PCS_HALF_DIV1000 : `PCS_HALF_DIV500;
   assign tmr_tick  = tick_src ? ext_rise : sys_rise;
   assign tick_half = tick_src ? `PCS_HALF_DIV32 : `PCS_HALF_DIV1000;

   pcs_divider u_dbl_div (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .restart    (restart),
      .tick       (dbl_tick),
      .half_count (dbl_half),
      .div_out    (dbl_div)
   );

   pcs_divider u_chop_div (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .restart    (restart),
      .tick       (sys_rise),
      .half_count (chop_half),
      .div_out    (chop_div)
   );

   pcs_divider u_tmr_div (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .restart    (restart),
      .tick       (tmr_tick),
      .half_count (tick_half),
      .div_out    (tmr_div)
   );

   // Output flops; one cycle behind the dividers but glitch free
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         doubler_clock   <= 1'b0;
         chopper_ctrl    <= 1'b0;
         timer_lcd_clock <= 1'b0;
      end else begin
         doubler_clock   <= dbl_div;
         timer_lcd_clock <= tmr_div;
         case (chop_sel)
            PCS_CHOP_LOW:  chopper_ctrl <= 1'b0;
            PCS_CHOP_HIGH: chopper_ctrl <= 1'b1;
            PCS_CHOP_D500: chopper_ctrl <= chop_div;
            PCS_CHOP_D1K:  chopper_ctrl <= chop_div;
            default:       chopper_ctrl <= 1'b0;
         endcase
      end
   end
endmodule

// *** verification/pcs_osc_model.sv ***
// Oscillator pin model for the two clock sources
`timescale 1ns/1ps
module pcs_osc_model #(
   parameter int INT_HALF_NS = 500,
   parameter int EXT_HALF_NS = 15259
) (
   // Oscillator pins
   output logic internal_osc_clock,
   output logic external_osc_clock
);
   initial begin
      internal_osc_clock = 1'b0;
      forever #(INT_HALF_NS) internal_osc_clock = ~internal_osc_clock;
   end
   // Offset start keeps the sources out of phase
   initial begin
      external_osc_clock = 1'b0;
      #7;
      forever #(EXT_HALF_NS) external_osc_clock = ~external_osc_clock;
   end
endmodule

// *** verification/pcs_clock_selector_checker.sv ***
// Port assertions for the clock selector
`timescale 1ns/1ps
module pcs_clock_selector_checker (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   // Oscillator pins
   input wire logic       internal_osc_clock,
   input wire logic       external_osc_clock,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Derived clocks
   input wire logic       main_clock,
   input wire logic       system_clock,
   input wire logic       doubler_clock,
   input wire logic       chopper_ctrl,
   input wire logic       timer_lcd_clock
);
   logic [7:0] mode_q;
   logic [7:0] per_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Shadow registers, so read data and restarts can be judged
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= 8'h00;
         per_q <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == 8'h14) mode_q <= reg_wdata;
         if (reg_addr == 8'h15) per_q <= reg_wdata;
      end
   end
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside answer");
   a_rdata_mode: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == mode_q)
      else $error("mode read back wrong");
   a_rdata_per: assert property (reg_rd && reg_addr == 8'h15 |=> reg_rdata == per_q)
      else $error("peripheral read back wrong");
   // Register lands, dividers clear next edge, output flops follow one edge later
   a_restart_all: assert property (reg_wr && (reg_addr == 8'h14 && reg_wdata != mode_q
      || reg_addr == 8'h15 && reg_wdata != per_q) |-> ##3 !doubler_clock && !timer_lcd_clock)
      else $error("dividers not restarted");
   a_chop_low: assert property ((per_q[3:2] == 2'b00)[*3] |-> !chopper_ctrl)
      else $error("chopper not low");
   a_chop_high: assert property ((per_q[3:2] == 2'b01)[*3] |-> chopper_ctrl)
      else $error("chopper not high");
   a_main_int: assert property ($rose(main_clock) && !mode_q[0] && !$past(mode_q[0], 8)
      |-> $past(internal_osc_clock, 2) || $past(internal_osc_clock, 3)
      || $past(internal_osc_clock, 4)) else $error("main not internal");
   a_main_ext: assert property ($rose(main_clock) && mode_q[0] && !mode_q[3]
      && $past(mode_q[0], 8) && !$past(mode_q[3], 8) |-> $past(external_osc_clock, 2)
      || $past(external_osc_clock, 3) || $past(external_osc_clock, 4))
      else $error("main not external");
   a_sys_direct: assert property ($rose(system_clock) && !mode_q[1]
      && !$past(mode_q[1], 8) |-> main_clock || $past(main_clock))
      else $error("system not main");
   c_chop_toggle: cover property (per_q[3] && $rose(chopper_ctrl));
   c_tick_ext: cover property (mode_q[5] && $rose(timer_lcd_clock));
   c_dbl_ext: cover property (mode_q[0] && $rose(doubler_clock));
endmodule
bind pcs_clock_selector pcs_clock_selector_checker pcs_clock_selector_checker_inst (.ref_clk,
   .sys_rst, .internal_osc_clock, .external_osc_clock, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .main_clock, .system_clock, .doubler_clock, .chopper_ctrl,
   .timer_lcd_clock);

// *** verification/testbench.sv ***
// Self-checking bench for the clock selector
`timescale 1ns/1ps
module testbench
   import pcs_pkg::*;
;
   logic       ref_clk, sys_rst, reg_wr, reg_rd, int_osc, ext_osc;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   wire  [4:0] outs;
   int         n_mismatch, check_count;
   // Short source periods in ref cycles keep the run brief
   localparam int IP = 10;
   localparam int EP = 13;
   pcs_osc_model #(.INT_HALF_NS(100), .EXT_HALF_NS(130)) pcs_osc_model_inst (
      .internal_osc_clock(int_osc), .external_osc_clock(ext_osc));
   pcs_clock_selector pcs_clock_selector_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .internal_osc_clock(int_osc), .external_osc_clock(ext_osc), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .main_clock(outs[0]), .system_clock(outs[1]), .doubler_clock(outs[2]),
      .chopper_ctrl(outs[3]), .timer_lcd_clock(outs[4]));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic final_report;
      if (n_mismatch == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp,
                        input int tol);
      check_count++;
      if ($isunknown(seen) || seen > exp + tol || seen + tol < exp) begin
         n_mismatch++;
         $display("Error %s expected %0d seen %0d", s, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", reg_rdata, e, 0);
      @(posedge ref_clk);
      #1;
      check("reg_rdata idle", reg_rdata, 8'h00, 0);
      @(posedge ref_clk);
   endtask
   // Rise to rise, sampled on the falling edge clear of output updates
   task automatic period(input int k, output int p);
      p = 0;
      for (int i = 0; i < 4; i++) begin
         if (i == 2) p = 0;
         while (outs[k] !== i[0] && p < 40000) begin
            @(negedge ref_clk);
            p++;
         end
      end
      @(posedge ref_clk);
      if (p >= 40000) begin
         n_mismatch++;
         final_report();
      end
   endtask
   task automatic t_regs;
      rd(8'h14, 8'h00);
      rd(8'h15, 8'h00);
      wr(8'h15, 8'ha1);
      rd(8'h15, 8'ha1);
      rd(8'h16, 8'h00);
   endtask
   task automatic t_main;
      logic [7:0] m [5] = '{8'h00, 8'h08, 8'h01, 8'h09, 8'h02};
      int e [5] = '{IP, IP, EP, 2 * EP, IP};
      int p;
      foreach (m[i]) begin
         wr(8'h14, m[i]);
         rd(8'h14, m[i]);
         period(0, p);
         check("main_clock", p, e[i], 2);
         period(1, p);
         check("system_clock", p, m[i][1] ? 4 * IP : e[i], 2);
      end
   endtask
   task automatic t_doubler;
      logic [7:0] m [4] = '{8'h00, 8'h00, 8'h01, 8'h01};
      logic [7:0] r [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
      int e [4] = '{200 * IP, 100 * IP, 32 * EP, 32 * EP};
      int p;
      foreach (m[i]) begin
         wr(8'h14, m[i]);
         wr(8'h15, r[i]);
         period(2, p);
         check("doubler_clock", p, e[i], 2);
      end
   endtask
   task automatic t_chop;
      pcs_chop_t c;
      int p;
      wr(8'h14, 8'h00);
      for (int i = 0; i < 4; i++) begin
         c = pcs_chop_t'(i);
         wr(8'h15, {4'h0, c, 2'b00});
         if (c == PCS_CHOP_LOW || c == PCS_CHOP_HIGH) begin
            repeat (30) @(posedge ref_clk);
            #1;
            check("chopper_ctrl", outs[3], c == PCS_CHOP_HIGH, 0);
         end else begin
            period(3, p);
            check("chopper_ctrl", p, c == PCS_CHOP_D500 ? 500 * IP : 1000 * IP, 2);
         end
      end
   endtask
   task automatic t_tick;
      logic [7:0] m [3] = '{8'h00, 8'h20, 8'h23};
      int e [3] = '{1000 * IP, 32 * EP, 32 * EP};
      int p;
      foreach (m[i]) begin
         wr(8'h14, m[i]);
         period(4, p);
         check("timer_lcd_clock", p, e[i], 2);
      end
   endtask
   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      n_mismatch = 0;
      check_count = 0;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_main();
      t_doubler();
      t_chop();
      t_tick();
      final_report();
   end
endmodule
